// file: core/mtca_pkg.sv
// Purpose: Shared constants and types for the MAC table access engine.
// Assumes: 32-bit APB register map; one aligned word per register.
// Notes:   Entry layout in table storage is {fid, mac, fields}.
//
// How it works
// [R1] Software stages the key and entry fields, then writes the command; the table is reached only by commands.
// [R2] Writing the trigger bit starts the command and the engine clears it itself on completion.
// [R3] Completion sets a done flag that raises the interrupt when its enable bit is set.
// [R4] The high staging register holds the top address bits and filtering identifier, the low one the rest.
// [R5] The entry staging register carries address, type, kill, learn-all, copy, ignore, age, mirror, lock, valid.
// [R6] Learn writes the hashed row and flags refresh, insert, replace, replace-failed, learn-failed or move.
// [R7] Unlearn clears the matching entry in its hashed row and flags success or failure.
// [R8] Lookup searches the hashed row for the key and flags success or failure.
// [R9] A successful lookup returns the found entry fields into the entry staging register.
// [R10] Direct read takes row, column and type from the control register with no hashing.
// [R11] A successful direct read fills all three staging registers and flags the read.
// [R12] Each finished command records the row and column it accessed in a position register.
// [R13] Sixteen extra identifier filters apply to a scan only when their control bit enables them.
// [R14] A last-row setting ends a scan and a counter reports matching entries while it runs.
// [R15] Keys are a 48-bit address with a 13-bit filtering identifier.
// [R16] The 3-bit address type tells unicast, processor, aggregated and multicast addresses apart.
// [R17] Software waits for the trigger bit to read zero before touching staging or reading results.
package mtca_pkg;
  localparam int APB_AW = 8;
  localparam logic [APB_AW-1:0] OFS_CTRL          = 8'h00;
  localparam logic [APB_AW-1:0] OFS_KEY_HIGH      = 8'h04;
  localparam logic [APB_AW-1:0] OFS_KEY_LOW       = 8'h08;
  localparam logic [APB_AW-1:0] OFS_ENTRY         = 8'h0c;
  localparam logic [APB_AW-1:0] OFS_STICKY        = 8'h10;
  localparam logic [APB_AW-1:0] OFS_STICKY_CLR    = 8'h14;
  localparam logic [APB_AW-1:0] OFS_INT_ENA       = 8'h18;
  localparam logic [APB_AW-1:0] OFS_SCAN_FID_CTRL = 8'h1c;
  localparam logic [APB_AW-1:0] OFS_SCAN_LAST_ROW = 8'h20;
  localparam logic [APB_AW-1:0] OFS_SCAN_COUNT    = 8'h24;
  localparam logic [APB_AW-1:0] OFS_POS_STATUS    = 8'h28;
  localparam logic [APB_AW-1:0] OFS_SCAN_FID      = 8'h40;
  localparam logic [APB_AW-1:0] OFS_SCAN_FID_LAST = 8'h7c;

  localparam int MAC_W     = 48;
  localparam int MAC_HI_W  = 16;
  localparam int MAC_LO_W  = 32;
  localparam int FID_W     = 13;
  localparam int KEY_W     = MAC_W + FID_W;
  localparam int FLD_W     = 26;
  localparam int ENT_W     = KEY_W + FLD_W;
  localparam int ENT_MAC_LSB = FLD_W;
  localparam int ENT_FID_LSB = FLD_W + MAC_W;
  localparam int KEYHI_FID_LSB = 16;

  localparam int CTRL_SHOT_BIT = 0;
  localparam int CTRL_CMD_LSB  = 1;
  localparam int CMD_W         = 3;
  localparam int CTRL_ROW_LSB  = 4;
  localparam int ROWF_W        = 12;
  localparam int CTRL_COL_LSB  = 16;
  localparam int COLF_W        = 4;
  localparam int CTRL_TYPE_LSB = 20;
  localparam int TYPEF_W       = 2;
  localparam logic [TYPEF_W-1:0] TYPE_MAIN = 2'h0;

  // Entry field positions
  localparam int FLD_ADDR_LSB  = 0;
  localparam int FLD_ATYPE_LSB = 12;
  localparam int FLD_ADDR_ALL  = 15;
  localparam int FLD_LOCKED    = 24;
  localparam int FLD_VLD       = 25;

  typedef enum logic [2:0] {
    ATYPE_UNICAST = 3'h0,
    ATYPE_CPU     = 3'h1,
    ATYPE_AGGR    = 3'h2,
    ATYPE_MCIDX   = 3'h3
  } mtca_atype_t;

  typedef enum logic [CMD_W-1:0] {
    CMD_LEARN       = 3'h0,
    CMD_UNLEARN     = 3'h1,
    CMD_LOOKUP      = 3'h2,
    CMD_READ_DIRECT = 3'h3,
    CMD_WRITE_DIRECT = 3'h4,
    CMD_SCAN        = 3'h5,
    CMD_FIND_SMALL  = 3'h6
  } mtca_cmd_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'h0,
    ST_FETCH = 2'h1,
    ST_EXEC  = 2'h3,
    ST_DONE  = 2'h2
  } mtca_state_t;

  localparam int STK_W            = 12;
  localparam int STK_REFRESH      = 0;
  localparam int STK_INSERT       = 1;
  localparam int STK_REPLACE      = 2;
  localparam int STK_REPLACE_FAIL = 3;
  localparam int STK_LRN_FAIL     = 4;
  localparam int STK_MOVE         = 5;
  localparam int STK_UNLEARN      = 6;
  localparam int STK_UNLEARN_FAIL = 7;
  localparam int STK_LOOKUP       = 8;
  localparam int STK_LOOKUP_FAIL  = 9;
  localparam int STK_READ         = 10;
  localparam int STK_DONE         = 11;

  localparam int NUM_SCAN_FID = 16;
  localparam int COUNT_W      = 16;
  localparam logic [ROWF_W-1:0] SCAN_LAST_ROW_RST = 12'hfff;
endpackage

// file: core/mtca_hash.sv
// Purpose: Folds the 61-bit key into a table row index.
// Assumes: Purely combinational; ROW_W at most 12.
// Notes:   XOR folding of {fid, mac} in ROW_W-bit slices.
module mtca_hash #(
  parameter int ROW_W = 4
) (
  input  wire logic [mtca_pkg::MAC_W-1:0] mac,
  input  wire logic [mtca_pkg::FID_W-1:0] fid,
  output logic      [ROW_W-1:0]           row
);
  import mtca_pkg::*;

  logic [KEY_W-1:0] key;

  assign key = {fid, mac};

  always_comb begin
    row = '0;
    for (int i = 0; i < KEY_W; i += ROW_W) begin
      row = row ^ ROW_W'(key >> i);
    end
  end
endmodule

// file: core/mtca_sticky_irq.sv
// Purpose: Sticky event status, enable mask and level interrupt.
// Assumes: Event and write strobes are one-cycle pulses on clk_sys.
// Notes:   A set in the same cycle as its clear wins.
module mtca_sticky_irq #(
  parameter int W = 12
) (
  input  wire logic         clk_sys,
  input  wire logic         nrst,
  input  wire logic [W-1:0] evt,
  input  wire logic         clrWr,
  input  wire logic         enaWr,
  input  wire logic [W-1:0] wdata,
  output logic      [W-1:0] status,
  output logic      [W-1:0] enable,
  output logic              irq
);
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      status <= '0;
    end else begin
      status <= (status & ~(clrWr ? wdata : '0)) | evt;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      enable <= '0;
    end else if (enaWr) begin
      enable <= wdata;
    end
  end

  // Level output while any enabled flag stands
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status & enable);
    end
  end
endmodule

// file: core/mtca_top.sv
// Purpose: Command-driven processor access to the hashed MAC table.
// Assumes: APB slave, one wait-free access phase; table held in flops.
// Notes:   Write direct and find smallest complete with no table effect.
//
// Local design decisions: the register addresses and the APB register port.
module mtca_top #(
  parameter int ROWS = 16,
  parameter int COLS = 4
) (
  input  wire logic                          clk_sys,
  input  wire logic                          nrst,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [mtca_pkg::APB_AW-1:0]   paddr,
  input  wire logic [31:0]                   pwdata,
  output logic      [31:0]                   prdata,
  output logic                               pready,
  output logic                               pslverr,
  output logic                               accessDoneIrq
);
  import mtca_pkg::*;

  localparam int ROW_W = $clog2(ROWS);
  localparam int COL_W = $clog2(COLS);

  if (ROWS < 2 || ROWS > 4096 || (1 << ROW_W) != ROWS || COLS < 2 || COLS > 16 || (1 << COL_W) != COLS) begin : g_chk
    $error("mtca_top: ROWS and COLS must be powers of two within range");
  end

  // Register state
  mtca_cmd_t           cmd;
  logic                trigger;
  logic [ROWF_W-1:0]   dirRow;
  logic [COLF_W-1:0]   dirCol;
  logic [TYPEF_W-1:0]  dirType;
  logic [FID_W-1:0]    stgFid;
  logic [MAC_HI_W-1:0] stgMacHi;
  logic [MAC_LO_W-1:0] stgMacLo;
  logic [FLD_W-1:0]    stgFields;
  logic                scanFidEna;
  logic [FID_W-1:0]    scanFid [NUM_SCAN_FID];
  logic [ROWF_W-1:0]   scanLastRow;
  logic [COUNT_W-1:0]  scanCount;
  logic [ROW_W-1:0]    posRow;
  logic [COL_W-1:0]    posCol;
  logic [STK_W-1:0]    stkStatus;
  logic [STK_W-1:0]    stkEnable;

  // Engine state
  mtca_state_t         state;
  logic [ROW_W-1:0]    rowIdx;
  logic [COL_W-1:0]    accCol;
  logic [ENT_W-1:0]    tbl [ROWS][COLS];
  logic [ENT_W-1:0]    rowBuf [COLS];
  logic [ROW_W-1:0]    hashRow;

  // Engine decisions
  logic                hitAny, freeAny, vicAny;
  logic [COL_W-1:0]    hitCol, freeCol, vicCol, actCol;
  logic [COL_W:0]      scanHits;
  logic                tblWe, ldKey, ldFields, readOk, scanEnd;
  logic [COL_W-1:0]    wrCol;
  logic [ENT_W-1:0]    wrData, retEnt, newEnt;
  logic [STK_W-1:0]    evt;

  // APB decode
  logic wrAcc;
  logic [32:0] rdSel;

  assign wrAcc = psel & penable & pready & pwrite;

  function automatic logic isScanFid(input logic [APB_AW-1:0] a);
    isScanFid = (a[1:0] == 2'h0) && (a >= OFS_SCAN_FID) && (a <= OFS_SCAN_FID_LAST);
  endfunction

  function automatic logic fidFiltered(input logic [FID_W-1:0] f);
    fidFiltered = 1'b0;
    for (int i = 0; i < NUM_SCAN_FID; i++) begin
      if (scanFid[i] == f) fidFiltered = 1'b1;
    end
  endfunction

  always_comb begin
    rdSel = '0;
    if (paddr == OFS_CTRL) begin
      rdSel = {1'b1, 10'h0, dirType, dirCol, dirRow, cmd, trigger};
    end else if (paddr == OFS_KEY_HIGH) begin
      rdSel = {1'b1, 3'h0, stgFid, stgMacHi};
    end else if (paddr == OFS_KEY_LOW) begin
      rdSel = {1'b1, stgMacLo};
    end else if (paddr == OFS_ENTRY) begin
      rdSel = {1'b1, 6'h0, stgFields};
    end else if (paddr == OFS_STICKY) begin
      rdSel = {1'b1, 20'h0, stkStatus};
    end else if (paddr == OFS_STICKY_CLR) begin
      rdSel = {1'b1, 32'h0};
    end else if (paddr == OFS_INT_ENA) begin
      rdSel = {1'b1, 20'h0, stkEnable};
    end else if (paddr == OFS_SCAN_FID_CTRL) begin
      rdSel = {1'b1, 31'h0, scanFidEna};
    end else if (paddr == OFS_SCAN_LAST_ROW) begin
      rdSel = {1'b1, 20'h0, scanLastRow};
    end else if (paddr == OFS_SCAN_COUNT) begin
      rdSel = {1'b1, 16'h0, scanCount};
    end else if (paddr == OFS_POS_STATUS) begin
      rdSel = {1'b1, 12'h0, COLF_W'(posCol), 4'h0, ROWF_W'(posRow)}; // R12
    end else if (isScanFid(paddr)) begin
      rdSel = {1'b1, 19'h0, scanFid[paddr[5:2]]};
    end
  end

  // Access phase follows every setup cycle directly
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      pready <= 1'b0;
    end else begin
      pready <= psel & ~penable;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end else if (psel & ~penable) begin
      prdata  <= pwrite ? 32'h0 : rdSel[31:0];
      pslverr <= ~rdSel[32];
    end
  end

  // Control register; held while a command runs
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      cmd     <= CMD_LEARN;
      trigger <= 1'b0;
      dirRow  <= '0;
      dirCol  <= '0;
      dirType <= '0;
    end else if (state == ST_DONE) begin
      trigger <= 1'b0; // R2
    end else if (wrAcc && paddr == OFS_CTRL && !trigger) begin
      cmd     <= mtca_cmd_t'(pwdata[CTRL_CMD_LSB +: CMD_W]); // R1
      trigger <= pwdata[CTRL_SHOT_BIT]; // R2
      dirRow  <= pwdata[CTRL_ROW_LSB +: ROWF_W];
      dirCol  <= pwdata[CTRL_COL_LSB +: COLF_W];
      dirType <= pwdata[CTRL_TYPE_LSB +: TYPEF_W];
    end
  end

  // Key staging: engine return wins over a software write
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      stgFid   <= '0;
      stgMacHi <= '0;
      stgMacLo <= '0;
    end else if (ldKey) begin
      stgFid   <= retEnt[ENT_FID_LSB +: FID_W]; // R11
      stgMacHi <= retEnt[ENT_MAC_LSB + MAC_LO_W +: MAC_HI_W];
      stgMacLo <= retEnt[ENT_MAC_LSB +: MAC_LO_W];
    end else if (wrAcc && paddr == OFS_KEY_HIGH) begin
      stgMacHi <= pwdata[MAC_HI_W-1:0]; // R4
      stgFid   <= pwdata[KEYHI_FID_LSB +: FID_W]; // R15
    end else if (wrAcc && paddr == OFS_KEY_LOW) begin
      stgMacLo <= pwdata; // R4
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      stgFields <= '0;
    end else if (ldFields) begin
      stgFields <= retEnt[FLD_W-1:0]; // R9
    end else if (wrAcc && paddr == OFS_ENTRY) begin
      stgFields <= pwdata[FLD_W-1:0]; // R5
    end
  end

  // Scan configuration
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      scanFidEna  <= 1'b0;
      scanLastRow <= SCAN_LAST_ROW_RST;
    end else if (wrAcc && paddr == OFS_SCAN_FID_CTRL) begin
      scanFidEna <= pwdata[0];
    end else if (wrAcc && paddr == OFS_SCAN_LAST_ROW) begin
      scanLastRow <= pwdata[ROWF_W-1:0];
    end
  end

  for (genvar g = 0; g < NUM_SCAN_FID; g++) begin : g_fid
    always_ff @(posedge clk_sys) begin
      if (!nrst) begin
        scanFid[g] <= '0;
      end else if (wrAcc && isScanFid(paddr) && paddr[5:2] == 4'(g)) begin
        scanFid[g] <= pwdata[FID_W-1:0]; // R13
      end
    end
  end

  mtca_hash #(
    .ROW_W (ROW_W)
  ) u_hash (
    .mac ({stgMacHi, stgMacLo}),
    .fid (stgFid),
    .row (hashRow)
  );

  // Command sequencer
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      state  <= ST_IDLE;
      rowIdx <= '0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (trigger) begin
            state <= ST_FETCH;
            if (cmd == CMD_LEARN || cmd == CMD_UNLEARN || cmd == CMD_LOOKUP) begin
              rowIdx <= hashRow; // R6 R7 R8
            end else begin
              rowIdx <= dirRow[ROW_W-1:0]; // R10
            end
          end
        end
        ST_FETCH: state <= ST_EXEC;
        ST_EXEC: begin
          if (cmd == CMD_SCAN && !scanEnd) begin
            rowIdx <= rowIdx + 1'b1;
            state  <= ST_FETCH;
          end else begin
            state <= ST_DONE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      for (int c = 0; c < COLS; c++) rowBuf[c] <= '0;
    end else if (state == ST_FETCH) begin
      for (int c = 0; c < COLS; c++) rowBuf[c] <= tbl[rowIdx][c];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      for (int r = 0; r < ROWS; r++) begin
        for (int c = 0; c < COLS; c++) tbl[r][c] <= '0;
      end
    end else if (tblWe) begin
      tbl[rowIdx][wrCol] <= wrData;
    end
  end

  // Row search: lowest matching, free and unlocked columns
  assign newEnt = {stgFid, stgMacHi, stgMacLo, stgFields};

  always_comb begin
    hitAny = 1'b0;
    freeAny = 1'b0;
    vicAny = 1'b0;
    hitCol = '0;
    freeCol = '0;
    vicCol = '0;
    scanHits = '0;
    for (int c = COLS - 1; c >= 0; c--) begin
      if (rowBuf[c][FLD_VLD] && rowBuf[c][ENT_W-1:FLD_W] == newEnt[ENT_W-1:FLD_W]) begin
        hitAny = 1'b1;
        hitCol = COL_W'(c);
      end
      if (!rowBuf[c][FLD_VLD]) begin
        freeAny = 1'b1;
        freeCol = COL_W'(c);
      end
      if (!rowBuf[c][FLD_LOCKED]) begin
        vicAny = 1'b1;
        vicCol = COL_W'(c);
      end
      if (rowBuf[c][FLD_VLD] && (!scanFidEna || fidFiltered(rowBuf[c][ENT_FID_LSB +: FID_W]))) begin // R13
        scanHits = scanHits + 1'b1;
      end
    end
  end

  assign readOk  = (int'(dirRow) < ROWS) && (int'(dirCol) < COLS) && (dirType == TYPE_MAIN);
  assign scanEnd = (ROWF_W'(rowIdx) == scanLastRow) || (rowIdx == ROW_W'(ROWS - 1)); // R14

  always_comb begin
    tblWe = 1'b0;
    ldKey = 1'b0;
    ldFields = 1'b0;
    wrCol = hitCol;
    actCol = hitCol;
    wrData = newEnt;
    retEnt = rowBuf[hitCol];
    evt = '0;
    if (state == ST_EXEC) begin
      case (cmd)
        CMD_LEARN: begin
          if (hitAny) begin
            tblWe = 1'b1; // R6
            // Same address and type means a refresh, otherwise the station moved
            if (rowBuf[hitCol][FLD_ADDR_LSB +: FLD_ADDR_ALL] == stgFields[FLD_ADDR_LSB +: FLD_ADDR_ALL]) begin // R16
              evt[STK_REFRESH] = 1'b1;
            end else begin
              evt[STK_MOVE] = 1'b1;
            end
          end else if (freeAny) begin
            tblWe = 1'b1;
            wrCol = freeCol;
            actCol = freeCol;
            evt[STK_INSERT] = 1'b1;
          end else if (vicAny) begin
            tblWe = 1'b1;
            wrCol = vicCol;
            actCol = vicCol;
            evt[STK_REPLACE] = 1'b1;
          end else begin
            evt[STK_REPLACE_FAIL] = 1'b1; // R6
            evt[STK_LRN_FAIL] = 1'b1;
          end
        end
        CMD_UNLEARN: begin
          if (hitAny) begin
            tblWe = 1'b1; // R7
            wrData = '0;
            evt[STK_UNLEARN] = 1'b1;
          end else begin
            evt[STK_UNLEARN_FAIL] = 1'b1;
          end
        end
        CMD_LOOKUP: begin
          if (hitAny) begin
            ldFields = 1'b1; // R9
            evt[STK_LOOKUP] = 1'b1; // R8
          end else begin
            evt[STK_LOOKUP_FAIL] = 1'b1;
          end
        end
        CMD_READ_DIRECT: begin
          actCol = dirCol[COL_W-1:0]; // R10
          retEnt = rowBuf[dirCol[COL_W-1:0]];
          if (readOk) begin
            ldKey = 1'b1; // R11
            ldFields = 1'b1;
            evt[STK_READ] = 1'b1;
          end
        end
        default: begin
          actCol = dirCol[COL_W-1:0];
        end
      endcase
    end
    if (state == ST_DONE) begin
      evt[STK_DONE] = 1'b1; // R3
    end
  end

  // Scan counter restarts with each scan and adds the matching entries of each visited row
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      scanCount <= '0;
    end else if (state == ST_IDLE && trigger && cmd == CMD_SCAN) begin
      scanCount <= '0;
    end else if (state == ST_EXEC && cmd == CMD_SCAN) begin
      scanCount <= scanCount + COUNT_W'(scanHits); // R14
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      accCol <= '0;
      posRow <= '0;
      posCol <= '0;
    end else if (state == ST_EXEC) begin
      accCol <= actCol;
    end else if (state == ST_DONE) begin
      posRow <= rowIdx; // R12
      posCol <= accCol;
    end
  end

  mtca_sticky_irq #(
    .W (STK_W)
  ) u_irq (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .evt     (evt),
    .clrWr   (wrAcc && paddr == OFS_STICKY_CLR),
    .enaWr   (wrAcc && paddr == OFS_INT_ENA),
    .wdata   (pwdata[STK_W-1:0]),
    .status  (stkStatus),
    .enable  (stkEnable),
    .irq     (accessDoneIrq)
  );
endmodule

// file: sim/mtca_properties.sv
// Purpose: Port checks for the table access engine.
// Assumes: Bound to mtca_top; one clock domain.
// Notes:   Counters track cycles since command starts and enable writes.
module mtca_properties (
  input wire logic                        clk_sys,
  input wire logic                        nrst,
  input wire logic                        psel,
  input wire logic                        penable,
  input wire logic                        pwrite,
  input wire logic [mtca_pkg::APB_AW-1:0] paddr,
  input wire logic [31:0]                 pwdata,
  input wire logic [31:0]                 prdata,
  input wire logic                        pready,
  input wire logic                        pslverr,
  input wire logic                        accessDoneIrq
);
  timeunit 1ns;
  timeprecision 1ps;
  import mtca_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  logic [3:0] trigCnt;
  logic [3:0] evtCnt;
  logic       scanRun;
  logic       wrDone;
  logic       badAddr;
  logic       clrEvt;
  logic       ctrlRd;
  assign wrDone = psel && penable && pready && pwrite;
  assign badAddr = !(paddr[1:0] == 2'h0 && (paddr <= OFS_POS_STATUS ||
                   (paddr >= OFS_SCAN_FID && paddr <= OFS_SCAN_FID_LAST)));
  assign clrEvt = wrDone && (paddr == OFS_STICKY_CLR || paddr == OFS_INT_ENA);
  assign ctrlRd = pready && !pwrite && paddr == OFS_CTRL;
  // Cycles since the last command start
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      trigCnt <= 4'hf;
      scanRun <= 1'b0;
    end else if (wrDone && paddr == OFS_CTRL && pwdata[0]) begin
      trigCnt <= 4'h0;
      scanRun <= pwdata[3:1] == CMD_SCAN;
    end else if (trigCnt != 4'hf) begin
      trigCnt <= trigCnt + 4'h1;
    end
  end
  // Cycles since the last start or enable write
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      evtCnt <= 4'hf;
    end else if (wrDone && (paddr == OFS_INT_ENA || (paddr == OFS_CTRL && pwdata[0]))) begin
      evtCnt <= 4'h0;
    end else if (evtCnt != 4'hf) begin
      evtCnt <= evtCnt + 4'h1;
    end
  end
  a_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("ready missing after setup");
  a_ready_in_access: assert property (pready |-> psel && penable)
    else $error("ready outside access");
  a_err_unmapped: assert property (pready |-> pslverr == badAddr)
    else $error("error flag wrong");
  a_wo_reads_zero: assert property (pready && (pwrite || paddr == OFS_STICKY_CLR) |-> prdata == 32'h0)
    else $error("read data not zero");
  a_trig_busy: assert property (ctrlRd && trigCnt <= 4'h4 |-> prdata[0])
    else $error("trigger cleared early");
  a_trig_clear: assert property (ctrlRd && trigCnt >= 4'h5 && !scanRun |-> !prdata[0])
    else $error("trigger not cleared");
  a_irq_cause: assert property ($rose(accessDoneIrq) |-> evtCnt <= 4'h5 || scanRun)
    else $error("interrupt without cause");
  a_irq_fall: assert property ($fell(accessDoneIrq) |-> $past(clrEvt, 2))
    else $error("interrupt fell without write");
endmodule

bind mtca_top mtca_properties mtca_properties_inst (.clk_sys(clk_sys), .nrst(nrst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .accessDoneIrq(accessDoneIrq));

// file: sim/mtca_tb.sv
// Purpose: Self-checking bench for the table access engine.
// Assumes: ROWS=16, COLS=4; bench is the APB master.
// Notes:   Expected rows come from a bench copy of the fold hash.
module mtca_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import mtca_pkg::*;
  logic        clk_sys;
  logic        nrst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        accessDoneIrq;
  logic        lastErr;
  logic [31:0] rdata;
  logic [31:0] rnd;
  logic [60:0] keys [4];
  logic [25:0] flds [4];
  logic [3:0]  rows [4];
  logic [3:0]  cols [4];
  logic [3:0]  occ [16];
  int          bad_count;
  int          checks;
  int          seed;
  int          cnt;

  mtca_top #(.ROWS(16), .COLS(4)) mtca_top_inst (.clk_sys(clk_sys), .nrst(nrst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .accessDoneIrq(accessDoneIrq));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic end_sim;
    $display("Checks %0d, mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic timed_out;
    bad_count++;
    $display("Error at %0t: wait bound used up", $time);
    end_sim();
  endtask

  function automatic logic [3:0] hashRow(input logic [60:0] k);
    logic [3:0] h;
    h = 4'h0;
    for (int i = 0; i < 61; i++) begin
      h[i%4] ^= k[i];
    end
    return h;
  endfunction

  function automatic logic [31:0] ctl(input logic [2:0] c, input logic [3:0] r, input logic [3:0] col,
                                      input logic [1:0] t);
    return {10'h0, t, col, 8'h0, r, c, 1'b1};
  endfunction

  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    @(posedge clk_sys);
    psel    <= 1'b1;
    penable <= 1'b0;
    paddr   <= a;
    pwrite  <= w;
    pwdata  <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) timed_out();
    rdata   = prdata;
    lastErr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(a, 1'b1, d);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    xfer(a, 1'b0, 32'h0);
    chk(rdata, exp);
  endtask

  task automatic run(input logic [31:0] c);
    int n;
    wr(OFS_STICKY_CLR, 32'hfff);
    wr(OFS_CTRL, c);
    n = 0;
    do begin
      xfer(OFS_CTRL, 1'b0, 32'h0);
      n++;
    end while (rdata[0] !== 1'b0 && n < 40);
    if (rdata[0] !== 1'b0) timed_out();
  endtask

  task automatic stage(input logic [60:0] k, input logic [25:0] f);
    wr(OFS_KEY_HIGH, {3'h0, k[60:32]});
    wr(OFS_KEY_LOW, k[31:0]);
    wr(OFS_ENTRY, {6'h0, f});
  endtask

  initial begin
    seed      = 32'h1dcb;
    bad_count = 0;
    checks    = 0;
    nrst      = 1'b0;
    psel      = 1'b0;
    penable   = 1'b0;
    pwrite    = 1'b0;
    paddr     = 8'h0;
    pwdata    = 32'h0;
    for (int i = 0; i < 16; i++) begin
      occ[i] = 4'h0;
    end
    repeat (20) @(posedge clk_sys);
    nrst <= 1'b1;
    for (int a = 0; a <= 40; a += 4) begin
      rdc(a[7:0], (a[7:0] == OFS_SCAN_LAST_ROW) ? 32'hfff : 32'h0);
    end
    xfer(8'h30, 1'b0, 32'h0);
    chk({31'h0, lastErr}, 32'h1);
    wr(OFS_INT_ENA, 32'h800);
    for (int i = 0; i < 4; i++) begin
      rnd = $random(seed);
      keys[i][60:32] = rnd[28:0];
      rnd = $random(seed);
      keys[i][31:0] = rnd;
      rnd = $random(seed);
      flds[i] = {2'b10, rnd[23:15], i[2:0], rnd[11:0]};
      stage(keys[i], flds[i]);
      run(ctl(CMD_LEARN, 4'h0, 4'h0, 2'h0));
      rows[i] = hashRow(keys[i]);
      cols[i] = occ[rows[i]];
      occ[rows[i]]++;
      rdc(OFS_STICKY, 32'h802);
      chk({31'h0, accessDoneIrq}, 32'h1);
      rdc(OFS_POS_STATUS, {12'h0, cols[i], 12'h0, rows[i]});
    end
    wr(OFS_INT_ENA, 32'h0);
    wr(OFS_STICKY, 32'h0);
    rdc(OFS_STICKY, 32'h802);
    chk({31'h0, accessDoneIrq}, 32'h0);
    wr(OFS_INT_ENA, 32'h800);
    stage(keys[0], flds[0]);
    run(ctl(CMD_LEARN, 4'h0, 4'h0, 2'h0));
    rdc(OFS_STICKY, 32'h801);
    flds[0][0] = ~flds[0][0];
    stage(keys[0], flds[0]);
    run(ctl(CMD_LEARN, 4'h0, 4'h0, 2'h0));
    rdc(OFS_STICKY, 32'h820);
    for (int i = 0; i < 4; i++) begin
      stage(keys[i], 26'h0);
      run(ctl(CMD_LOOKUP, 4'h0, 4'h0, 2'h0));
      rdc(OFS_STICKY, 32'h900);
      rdc(OFS_ENTRY, {6'h0, flds[i]});
    end
    stage(61'h0, 26'h0);
    run(ctl(CMD_READ_DIRECT, rows[1], cols[1], 2'h0));
    rdc(OFS_STICKY, 32'hc00);
    rdc(OFS_KEY_HIGH, {3'h0, keys[1][60:32]});
    rdc(OFS_KEY_LOW, keys[1][31:0]);
    rdc(OFS_ENTRY, {6'h0, flds[1]});
    run(ctl(CMD_READ_DIRECT, rows[1], cols[1], 2'h1));
    rdc(OFS_STICKY, 32'h800);
    stage(keys[2], 26'h0);
    run(ctl(CMD_UNLEARN, 4'h0, 4'h0, 2'h0));
    rdc(OFS_STICKY, 32'h840);
    run(ctl(CMD_UNLEARN, 4'h0, 4'h0, 2'h0));
    rdc(OFS_STICKY, 32'h880);
    run(ctl(CMD_LOOKUP, 4'h0, 4'h0, 2'h0));
    rdc(OFS_STICKY, 32'ha00);
    cnt = 0;
    for (int i = 0; i < 4; i++) begin
      if (i != 2 && keys[i][60:48] == keys[3][60:48]) cnt++;
    end
    wr(OFS_SCAN_FID, {19'h0, keys[3][60:48]});
    wr(OFS_SCAN_FID_CTRL, 32'h1);
    run(ctl(CMD_SCAN, 4'h0, 4'h0, 2'h0));
    rdc(OFS_SCAN_COUNT, 32'(cnt));
    wr(OFS_SCAN_FID_CTRL, 32'h0);
    run(ctl(CMD_SCAN, 4'h0, 4'h0, 2'h0));
    rdc(OFS_SCAN_COUNT, 32'h3);
    rdc(OFS_POS_STATUS, 32'hf);
    cnt = 0;
    for (int i = 0; i < 4; i++) begin
      if (i != 2 && rows[i] <= 4'h7) cnt++;
    end
    wr(OFS_SCAN_LAST_ROW, 32'h7);
    run(ctl(CMD_SCAN, 4'h0, 4'h0, 2'h0));
    rdc(OFS_POS_STATUS, 32'h7);
    rdc(OFS_SCAN_COUNT, 32'(cnt));
    run(ctl(CMD_WRITE_DIRECT, 4'h0, 4'h0, 2'h0));
    rdc(OFS_STICKY, 32'h800);
    run(ctl(CMD_FIND_SMALL, 4'h0, 4'h0, 2'h0));
    rdc(OFS_STICKY, 32'h800);
    end_sim();
  end
endmodule
